// ==== design/ddrpq_pkg.sv ====
// Package: register map, field layout, reset values and carrier types
package ddrpq_pkg;

  // ********************************************************************
  // Register byte addresses
  // ********************************************************************
  localparam logic [7:0] ADDR_AGING_CFG  = 8'h00; // priority_aging_config
  localparam logic [7:0] ADDR_EVT_CNT1   = 8'h04; // event_counter_one
  localparam logic [7:0] ADDR_EVT_CNT2   = 8'h08; // event_counter_two
  localparam logic [7:0] ADDR_EVT_CFG    = 8'h0c; // event_counter_config
  localparam logic [7:0] ADDR_EVT_SEL    = 8'h10; // event_filter_select
  localparam logic [7:0] ADDR_ELAPSED    = 8'h14; // elapsed_cycle_counter
  localparam logic [7:0] ADDR_IRQ_RAW    = 8'h18; // interrupt_raw_flags
  localparam logic [7:0] ADDR_IRQ_STAT   = 8'h1c; // enabled status, W1C
  localparam logic [7:0] ADDR_IRQ_ENSET  = 8'h20; // enable set view
  localparam logic [7:0] ADDR_IRQ_ENCLR  = 8'h24; // enable clear view

  // ********************************************************************
  // Field layout and reset values
  // ********************************************************************
  localparam logic [31:0] AGING_CFG_MASK = 32'h00ff_ffff;
  localparam logic [31:0] AGING_CFG_RST  = 32'h00ff_ffff;
  localparam logic [31:0] EVT_CFG_MASK   = 32'hc00f_c00f;
  localparam logic [31:0] EVT_SEL_MASK   = 32'hff0f_ff0f;
  localparam logic [31:0] IRQ_BITS_MASK  = 32'h0000_0039;
  localparam int          CLS1_LSB       = 16;
  localparam int          CLS2_LSB       = 8;
  localparam int          OLD_LSB        = 0;
  localparam int          TYPE1_LSB      = 0;
  localparam int          TYPE2_LSB      = 16;
  localparam int          MEN1_BIT       = 15;
  localparam int          REN1_BIT       = 14;
  localparam int          MEN2_BIT       = 31;
  localparam int          REN2_BIT       = 30;
  localparam int          MST1_LSB       = 8;
  localparam int          MST2_LSB       = 24;
  localparam int          SPC1_LSB       = 0;
  localparam int          SPC2_LSB       = 16;
  localparam int          SGL_ECC_BIT    = 5;
  localparam int          DBL_ECC_BIT    = 4;
  localparam int          WR_ECC_BIT     = 3;
  localparam int          BUS_FAULT_BIT  = 0;
  localparam logic [3:0]  SPACE_EXT_MEM  = 4'h0; // external memory space
  localparam logic [3:0]  SPACE_CTRL_REG = 4'h7; // controller registers
  // Event types that honour the master and region filters
  localparam logic [15:0] FILTERABLE_TYPES = 16'hffff;

  // ********************************************************************
  // Timing
  // ********************************************************************
  localparam int          AGING_UNIT_CYC = 16; // cycles per aging step
  localparam int          AGING_CNT_W    = 12; // 8-bit value times 16

  // ********************************************************************
  // Carrier types
  // ********************************************************************
  typedef struct packed {
    logic        wr;    // write strobe
    logic        rd;    // read strobe
    logic [7:0]  addr;  // byte address
    logic [31:0] wdata; // write data
  } ddrpq_bus_req_type;

  typedef struct packed {
    logic [15:0] hit;    // one pulse per event type this cycle
    logic [7:0]  master; // bus master of the access behind the event
    logic [3:0]  space;  // memory region of that access
  } ddrpq_perf_evt_type;

  typedef struct packed {
    logic single_bit_ecc_flag;
    logic double_bit_ecc_flag;
    logic write_ecc_flag;
    logic bus_cmd_addr_fault_flag;
  } ddrpq_err_evt_type;

endpackage

// ==== design/ddrpq_regs.sv ====
// Perf, priority aging and interrupt register bank of the DDR controller
//
// Strobed register access and the placing of the registers were decided locally.
`timescale 1ns/10ps

// ********************************************************************
// Aging interval timer
// ********************************************************************
module ddrpq_aging_timer (
  input  wire logic       clk,      // controller clock
  input  wire logic       srst,     // synchronous reset, active high
  input  wire logic [7:0] interval, // aging value in units of 16 cycles
  output logic            raise     // one-cycle priority raise pulse
);
  import ddrpq_pkg::*;

  logic [AGING_CNT_W-1:0] cnt_r;
  logic [AGING_CNT_W-1:0] target;
  logic                   fire;

  // Target is value x 16; a zero value raises on every cycle
  assign target = AGING_CNT_W'(interval * AGING_UNIT_CYC);
  // A shrunk interval fires at once instead of waiting for a wrap
  assign fire = (target == '0) || (cnt_r >= target - 12'h001);

  // Free running age counter, restarted by each raise
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_r <= '0;
      raise <= 1'b0;
    end else begin
      cnt_r <= fire ? '0 : cnt_r + 12'h001;
      raise <= fire;
    end
  end
endmodule

// Contract
// R1: Reserved bits read as zero; writes to them change nothing.
// R2: Class-1 aging value bits 23-16, reset 0xFF, raises class-1 priority.
// R3: Class-2 aging value bits 15-8, reset all ones, raises class-2 priority.
// R4: Oldest aging value bits 7-0, reset all ones, raises oldest command.
// R5: Two read-only 32-bit event counters count their selected events.
// R6: Event type selector bits 3-0 for counter one, 19-16 for two.
// R7: Master filter enable bits 15 and 31 restrict to programmed master.
// R8: Region filter enable bits 14 and 30 restrict to programmed region.
// R9: Master identifiers held in bits 15-8 and 31-24 of select register.
// R10: Region code 0x0 external memory, 0x7 controller registers.
// R11: Filters apply only to filterable event types; others always count.
// R12: Read-only elapsed counter increments every half-rate cycle after reset.
// R13: Raw status bits 5,4,3 hold single, double, write ECC errors.
// R14: Raw status bit 0 holds bus command or address fault.
// R15: Writing 1 sets a raw status bit; writing 0 does nothing.
// R16: Writing 1 to enabled status clears it and the raw bit.
// R17: Writing 1 to enable set enables source; both views read set.
// R18: Interrupt output high while any enabled raw status bit set.
// R19: Counters start at zero after reset and wrap on overflow.
module ddrpq_regs (
  input  wire logic                         clk,        // controller clock
  input  wire logic                         srst,       // sync reset
  input  wire ddrpq_pkg::ddrpq_bus_req_type bus_req,    // register access
  output logic [31:0]                       rdata,      // read data
  input  wire ddrpq_pkg::ddrpq_perf_evt_type perf_evt,  // monitor events
  input  wire ddrpq_pkg::ddrpq_err_evt_type  err_evt,   // error pulses
  output logic                              class1_raise, // class-1 bump
  output logic                              class2_raise, // class-2 bump
  output logic                              oldest_raise, // oldest bump
  output logic                              irq         // level interrupt
);
  import ddrpq_pkg::*;

  // ********************************************************************
  // Registers
  // ********************************************************************
  logic [31:0] aging_cfg_r;
  logic [31:0] evt_cfg_r;
  logic [31:0] evt_sel_r;
  logic [31:0] cnt1_r;
  logic [31:0] cnt2_r;
  logic [31:0] elapsed_r;
  logic [31:0] raw_r;
  logic [31:0] raw_nxt;
  logic [31:0] en_r;
  logic [31:0] en_nxt;
  logic [31:0] rdata_nxt;
  logic [31:0] hw_set;
  logic [31:0] raw_clr;
  logic [31:0] en_status;
  logic        hit1;
  logic        hit2;

  // Decoded strobes
  logic wr_aging;
  logic wr_cfg;
  logic wr_sel;
  logic wr_raw;
  logic wr_stat;
  logic wr_enset;
  logic wr_enclr;
  logic rd_stat;

  assign wr_aging = bus_req.wr && (bus_req.addr == ADDR_AGING_CFG);
  assign wr_cfg   = bus_req.wr && (bus_req.addr == ADDR_EVT_CFG);
  assign wr_sel   = bus_req.wr && (bus_req.addr == ADDR_EVT_SEL);
  assign wr_raw   = bus_req.wr && (bus_req.addr == ADDR_IRQ_RAW);
  assign wr_stat  = bus_req.wr && (bus_req.addr == ADDR_IRQ_STAT);
  assign wr_enset = bus_req.wr && (bus_req.addr == ADDR_IRQ_ENSET);
  assign wr_enclr = bus_req.wr && (bus_req.addr == ADDR_IRQ_ENCLR);
  assign rd_stat  = bus_req.rd && (bus_req.addr == ADDR_IRQ_STAT);

  // ********************************************************************
  // Configuration registers
  // ********************************************************************
  // Only defined fields are stored so reserved bits can never leak
  always_ff @(posedge clk) begin
    if (srst) begin
      aging_cfg_r <= AGING_CFG_RST; // see R2 see R3 see R4
      evt_cfg_r   <= '0;
      evt_sel_r   <= '0;
    end else begin
      if (wr_aging) begin
        aging_cfg_r <= bus_req.wdata & AGING_CFG_MASK; // see R1
      end
      if (wr_cfg) begin
        evt_cfg_r <= bus_req.wdata & EVT_CFG_MASK; // see R1 see R6
      end
      if (wr_sel) begin
        evt_sel_r <= bus_req.wdata & EVT_SEL_MASK; // see R9 see R10
      end
    end
  end

  // ********************************************************************
  // Priority aging
  // ********************************************************************
  ddrpq_aging_timer u_age_cls1 (
    .clk      (clk),
    .srst     (srst),
    .interval (aging_cfg_r[CLS1_LSB +: 8]), // see R2
    .raise    (class1_raise)
  );

  ddrpq_aging_timer u_age_cls2 (
    .clk      (clk),
    .srst     (srst),
    .interval (aging_cfg_r[CLS2_LSB +: 8]), // see R3
    .raise    (class2_raise)
  );

  ddrpq_aging_timer u_age_old (
    .clk      (clk),
    .srst     (srst),
    .interval (aging_cfg_r[OLD_LSB +: 8]), // see R4
    .raise    (oldest_raise)
  );

  // ********************************************************************
  // Event filtering
  // ********************************************************************
  // Unfilterable types ignore the filters; region codes other than the
  // two defined ones simply never match a real access
  function automatic logic evt_match(
    input logic [3:0] etype,
    input logic       men,
    input logic       ren,
    input logic [7:0] mst,
    input logic [3:0] spc,
    input ddrpq_perf_evt_type ev
  );
    logic pass;
    pass = (!men || (ev.master == mst)) && (!ren || (ev.space == spc));
    evt_match = ev.hit[etype] && (!FILTERABLE_TYPES[etype] || pass);
  endfunction

  assign hit1 = evt_match(evt_cfg_r[TYPE1_LSB +: 4], evt_cfg_r[MEN1_BIT],
                          evt_cfg_r[REN1_BIT], evt_sel_r[MST1_LSB +: 8],
                          evt_sel_r[SPC1_LSB +: 4],
                          perf_evt); // see R7 see R8 see R11
  assign hit2 = evt_match(evt_cfg_r[TYPE2_LSB +: 4], evt_cfg_r[MEN2_BIT],
                          evt_cfg_r[REN2_BIT], evt_sel_r[MST2_LSB +: 8],
                          evt_sel_r[SPC2_LSB +: 4],
                          perf_evt); // see R7 see R8 see R11

  // ********************************************************************
  // Counters
  // ********************************************************************
  // Plain 32-bit adders wrap to zero on overflow
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt1_r <= '0; // see R19
      cnt2_r <= '0;
    end else begin
      if (hit1) begin
        cnt1_r <= cnt1_r + 32'h0000_0001; // see R5
      end
      if (hit2) begin
        cnt2_r <= cnt2_r + 32'h0000_0001; // see R5
      end
    end
  end

  // The block clock is the half-rate memory clock, so count every edge
  always_ff @(posedge clk) begin
    if (srst) begin
      elapsed_r <= '0; // see R19
    end else begin
      elapsed_r <= elapsed_r + 32'h0000_0001; // see R12
    end
  end

  // ********************************************************************
  // Interrupt status and enables
  // ********************************************************************
  always_comb begin
    hw_set = '0;
    hw_set[SGL_ECC_BIT]   = err_evt.single_bit_ecc_flag;     // see R13
    hw_set[DBL_ECC_BIT]   = err_evt.double_bit_ecc_flag;     // see R13
    hw_set[WR_ECC_BIT]    = err_evt.write_ecc_flag;          // see R13
    hw_set[BUS_FAULT_BIT] = err_evt.bus_cmd_addr_fault_flag; // see R14
  end

  assign en_status = raw_r & en_r;

  // A read of the enabled status clears what it returned; a new event in
  // the same cycle still wins over any clear
  always_comb begin
    raw_clr = '0;
    if (wr_stat) begin
      raw_clr = bus_req.wdata & IRQ_BITS_MASK; // see R16
    end else if (rd_stat) begin
      raw_clr = en_status;
    end
    raw_nxt = (raw_r & ~raw_clr) | hw_set;
    if (wr_raw) begin
      raw_nxt = raw_nxt | (bus_req.wdata & IRQ_BITS_MASK); // see R15
    end
  end

  // Both enable views share one register
  always_comb begin
    en_nxt = en_r;
    if (wr_enset) begin
      en_nxt = en_r | (bus_req.wdata & IRQ_BITS_MASK); // see R17
    end else if (wr_enclr) begin
      en_nxt = en_r & ~(bus_req.wdata & IRQ_BITS_MASK);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      raw_r <= '0; // see R13
      en_r  <= '0;
    end else begin
      raw_r <= raw_nxt;
      en_r  <= en_nxt;
    end
  end

  assign irq = |en_status; // see R18

  // ********************************************************************
  // Read path
  // ********************************************************************
  // Unmapped addresses read zero; data stands one cycle only
  always_comb begin
    case (bus_req.addr)
      ADDR_AGING_CFG: rdata_nxt = aging_cfg_r;
      ADDR_EVT_CNT1:  rdata_nxt = cnt1_r;
      ADDR_EVT_CNT2:  rdata_nxt = cnt2_r;
      ADDR_EVT_CFG:   rdata_nxt = evt_cfg_r;
      ADDR_EVT_SEL:   rdata_nxt = evt_sel_r;
      ADDR_ELAPSED:   rdata_nxt = elapsed_r;
      ADDR_IRQ_RAW:   rdata_nxt = raw_r;
      ADDR_IRQ_STAT:  rdata_nxt = en_status;
      ADDR_IRQ_ENSET: rdata_nxt = en_r; // see R17
      ADDR_IRQ_ENCLR: rdata_nxt = en_r;
      default:        rdata_nxt = '0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rdata <= '0;
    end else begin
      rdata <= bus_req.rd ? rdata_nxt : 32'h0000_0000; // see R1
    end
  end

  // ********************************************************************
  // Assertions
  // ********************************************************************
  sequence rd_aging_seq;
    bus_req.rd && (bus_req.addr == ADDR_AGING_CFG);
  endsequence

  sequence raw_set_seq;
    wr_raw && bus_req.wdata[BUS_FAULT_BIT];
  endsequence

  AST_RSVD_ZERO: assert property (@(posedge clk) disable iff (srst) // see R1
    rd_aging_seq |=> (rdata[31:24] == 8'h00))
    else $error("reserved aging bits read nonzero");

  AST_AGING_RESET: assert property (@(posedge clk) // see R2
    $fell(srst) |-> (aging_cfg_r == AGING_CFG_RST))
    else $error("aging config not at reset value");

  AST_CLS2_SPACING: assert property (@(posedge clk) disable iff (srst) // see R3
    (class2_raise && (aging_cfg_r[CLS2_LSB +: 8] != 8'h00) && !wr_aging)
      ##1 !wr_aging [*8] |-> !class2_raise [*8] ##0 1'b1)
    else $error("class-2 raise repeated too soon");

  sequence old_one_seq;
    aging_cfg_r[OLD_LSB +: 8] == 8'h01;
  endsequence

  // The value must stay at one over the whole period, else a rewrite
  // changes the spacing and the check would be meaningless
  AST_OLD_PERIOD: assert property (@(posedge clk) disable iff (srst) // see R4
    oldest_raise ##0 old_one_seq ##1 old_one_seq [*8]
      ##1 old_one_seq [*7] |=> oldest_raise)
    else $error("oldest raise period wrong");

  AST_CNT1_INC: assert property (@(posedge clk) disable iff (srst) // see R5
    hit1 |=> (cnt1_r == $past(cnt1_r) + 32'h0000_0001))
    else $error("counter one missed an event");

  AST_MST_FILTER: assert property (@(posedge clk) disable iff (srst) // see R7
    evt_cfg_r[MEN2_BIT] && (perf_evt.master != evt_sel_r[MST2_LSB +: 8])
      && FILTERABLE_TYPES[evt_cfg_r[TYPE2_LSB +: 4]] |=> $stable(cnt2_r))
    else $error("counter two counted a filtered master");

  AST_ELAPSED: assert property (@(posedge clk) disable iff (srst) // see R12
    !$past(srst) |-> (elapsed_r == $past(elapsed_r) + 32'h0000_0001))
    else $error("elapsed counter did not advance");

  AST_RAW_W1S: assert property (@(posedge clk) disable iff (srst) // see R15
    raw_set_seq |=> raw_r[BUS_FAULT_BIT])
    else $error("raw write one did not set");

  AST_STAT_CLR: assert property (@(posedge clk) disable iff (srst) // see R16
    wr_stat && bus_req.wdata[SGL_ECC_BIT] && !err_evt.single_bit_ecc_flag
      |=> !raw_r[SGL_ECC_BIT])
    else $error("status clear left raw bit set");

  AST_IRQ_FOLLOW: assert property (@(posedge clk) disable iff (srst) // see R18
    raw_set_seq ##1 en_r[BUS_FAULT_BIT] |-> irq)
    else $error("enabled raw bit gave no interrupt");

  AST_CNT_START: assert property (@(posedge clk) // see R19
    $fell(srst) |-> (cnt1_r == '0) && (cnt2_r == '0) && (elapsed_r == '0))
    else $error("counters not zero after reset");

  // Hardware error pulses land in the raw flags one cycle later
  AST_DBL_SET: assert property (@(posedge clk) disable iff (srst) // see R13
    err_evt.double_bit_ecc_flag |=> raw_r[DBL_ECC_BIT])
    else $error("double-bit ECC event not recorded");

  AST_FLT_SET: assert property (@(posedge clk) disable iff (srst) // see R14
    err_evt.bus_cmd_addr_fault_flag |=> raw_r[BUS_FAULT_BIT])
    else $error("bus fault event not recorded");

  // Reserved raw positions can never hold a one
  AST_RSVD_RAW: assert property (@(posedge clk) disable iff (srst) // see R1
    (raw_r & ~IRQ_BITS_MASK) == 32'h0000_0000)
    else $error("reserved raw flag set");

  AST_ENSET_ON: assert property (@(posedge clk) disable iff (srst) // see R17
    wr_enset && bus_req.wdata[WR_ECC_BIT] |=> en_r[WR_ECC_BIT])
    else $error("enable set write did not enable");

  // A foreign region must never move counter one while filtering
  AST_RGN_FILTER: assert property (@(posedge clk) disable iff (srst) // see R8
    evt_cfg_r[REN1_BIT] && (perf_evt.space != evt_sel_r[SPC1_LSB +: 4])
      && FILTERABLE_TYPES[evt_cfg_r[TYPE1_LSB +: 4]] |=> $stable(cnt1_r))
    else $error("counter one counted a filtered region");

  AST_CNT2_HOLD: assert property (@(posedge clk) disable iff (srst) // see R5
    !hit2 |=> $stable(cnt2_r))
    else $error("counter two moved without an event");

endmodule

// ==== test/ddrpq_evt_source.sv ====
// Event source model standing in for bus masters and memory error paths
`timescale 1ns/10ps

// ********************************************************************
// Random monitor events and requested error pulses
// ********************************************************************
module ddrpq_evt_source (
  input  wire logic                     clk,      // controller clock
  input  wire logic                     go,       // emit random events
  input  wire logic [3:0]               err_req,  // error pulse request
  output ddrpq_pkg::ddrpq_perf_evt_type perf_evt, // monitor events
  output ddrpq_pkg::ddrpq_err_evt_type  err_evt   // error pulses
);
  import ddrpq_pkg::*;

  initial begin
    perf_evt = '0;
    err_evt  = '0;
  end

  // Few masters and two regions so the filters hit often; when idle the
  // qualifiers toggle so nothing may rely on them
  always @(posedge clk) begin
    if (go) begin
      perf_evt.hit    <= 16'($urandom);
      perf_evt.master <= 8'($urandom_range(3, 0));
      perf_evt.space  <= ($urandom_range(1, 0) != 0) ? SPACE_CTRL_REG
                                                     : SPACE_EXT_MEM;
    end else begin
      perf_evt.hit    <= '0;
      perf_evt.master <= ~perf_evt.master;
      perf_evt.space  <= ~perf_evt.space;
    end
  end

  // Error pulses follow the request one cycle later and last as long as it
  always @(posedge clk) begin
    err_evt <= ddrpq_err_evt_type'(err_req);
  end
endmodule

// ==== test/testbench.sv ====
// Self-checking bench for the perf, aging and interrupt register bank
`timescale 1ns/10ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin \
  miscompares++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module testbench;
  import ddrpq_pkg::*;
  logic               clk, srst, go, irq;
  logic               class1_raise, class2_raise, oldest_raise;
  logic [3:0]         err_req;
  logic [31:0]        rdata, cfg_s, sel_s, exp1, exp2, v, w, b;
  ddrpq_bus_req_type  bus_req;
  ddrpq_perf_evt_type perf_evt;
  ddrpq_err_evt_type  err_evt;
  int                 miscompares, comparisons, n, i;
  int                 bitpos[4] = '{0, 3, 4, 5}; // raw bit per struct slot
  logic [7:0]         ra[10] = '{ADDR_AGING_CFG, ADDR_EVT_CNT1,
    ADDR_EVT_CNT2, ADDR_EVT_CFG, ADDR_EVT_SEL, ADDR_IRQ_RAW, ADDR_IRQ_STAT,
    ADDR_IRQ_ENSET, ADDR_IRQ_ENCLR, 8'h28};
  logic [31:0]        wv[5] = '{AGING_CFG_MASK, 32'h0, 32'h0, EVT_CFG_MASK,
    EVT_SEL_MASK};

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  ddrpq_regs DUT (.clk(clk), .srst(srst), .bus_req(bus_req), .rdata(rdata),
    .perf_evt(perf_evt), .err_evt(err_evt), .class1_raise(class1_raise),
    .class2_raise(class2_raise), .oldest_raise(oldest_raise), .irq(irq));

  ddrpq_evt_source src (.clk(clk), .go(go), .err_req(err_req),
    .perf_evt(perf_evt), .err_evt(err_evt));

  // ********************************************************************
  // Expected counts, from the bench's own copy of the filter setup
  // ********************************************************************
  function automatic logic counts(logic [3:0] t, logic men, logic ren,
    logic [7:0] m, logic [3:0] s, ddrpq_perf_evt_type e);
    logic pass;
    pass = (!men || e.master === m) && (!ren || e.space === s);
    return e.hit[t] && (!FILTERABLE_TYPES[t] || pass);
  endfunction

  // Shadows change at the same edge as the design's copy
  always @(posedge clk) begin
    if (srst) begin
      exp1 <= '0;
      exp2 <= '0;
    end else begin
      exp1 <= exp1 + 32'(counts(cfg_s[TYPE1_LSB+:4], cfg_s[MEN1_BIT],
        cfg_s[REN1_BIT], sel_s[MST1_LSB+:8], sel_s[SPC1_LSB+:4], perf_evt));
      exp2 <= exp2 + 32'(counts(cfg_s[TYPE2_LSB+:4], cfg_s[MEN2_BIT],
        cfg_s[REN2_BIT], sel_s[MST2_LSB+:8], sel_s[SPC2_LSB+:4], perf_evt));
    end
  end

  // ********************************************************************
  // Bus tasks and helpers
  // ********************************************************************
  task automatic tick;
    @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    bus_req.wr <= 1'b0;
    if (a == ADDR_EVT_CFG) cfg_s <= d & EVT_CFG_MASK;
    if (a == ADDR_EVT_SEL) sel_s <= d & EVT_SEL_MASK;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clk);
    bus_req.rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    `CHK(d, e)
  endtask

  function automatic logic raise_of(int s);
    return (s == 0) ? class1_raise : (s == 1) ? class2_raise : oldest_raise;
  endfunction

  // Cycles between two raise pulses; a missing pulse ends the run
  task automatic period(input int s, output int p);
    int k;
    p = 0;
    for (k = 0; k < 5000 && raise_of(s) !== 1'b1; k++) tick();
    do begin
      tick();
      p++;
    end while (raise_of(s) !== 1'b1 && p < 5000);
    if (k >= 5000 || raise_of(s) !== 1'b1) begin
      miscompares++;
      final_report();
    end
  endtask

  task automatic final_report;
    $display("TB: compared %0d bad %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ********************************************************************
  // Main sequence
  // ********************************************************************
  initial begin
    srst = 1'b1;
    go = 1'b0;
    err_req = '0;
    bus_req = '0;
    cfg_s = '0;
    sel_s = '0;
    void'($urandom(83));
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    // Reset values, then all-ones writes incl. RO counters and a hole
    for (i = 0; i < 10; i++) begin
      chk_rd(ra[i], (i == 0) ? AGING_CFG_RST : 0);
    end
    for (i = 0; i < 10; i++) begin
      if (i < 5 || i == 9) begin
        wr(ra[i], 32'hffff_ffff);
        chk_rd(ra[i], (i < 5) ? wv[i] : 32'h0);
      end
    end
    rd(ADDR_ELAPSED, v);
    rd(ADDR_ELAPSED, w);
    `CHK(w - v, 32'h2)
    // Aging periods: default, small values, and zero
    period(0, n);
    `CHK(n, 4080)
    wr(ADDR_AGING_CFG, 32'hff02_0100);
    period(0, n);
    `CHK(n, 32)
    period(1, n);
    `CHK(n, 16)
    period(2, n);
    `CHK(n, 1)
    wr(ADDR_AGING_CFG, 32'h00ff_0001);
    period(2, n);
    `CHK(n, 16)
    wr(ADDR_AGING_CFG, 32'h00ff_0003);
    period(2, n);
    `CHK(n, 48)
    // Filtered counting; first pass runs unfiltered
    for (i = 0; i < 8; i++) begin
      v = (i == 0) ? 32'h0005_0003 : $urandom;
      w = $urandom & 32'h0300_0300;
      w[SPC1_LSB+:4] = $urandom_range(1, 0) ? SPACE_CTRL_REG : SPACE_EXT_MEM;
      w[SPC2_LSB+:4] = $urandom_range(1, 0) ? SPACE_CTRL_REG : SPACE_EXT_MEM;
      wr(ADDR_EVT_CFG, v);
      wr(ADDR_EVT_SEL, (i == 0) ? 32'h0 : w);
      go <= 1'b1;
      repeat (200) @(posedge clk);
      go <= 1'b0;
      repeat (3) @(posedge clk);
      chk_rd(ADDR_EVT_CNT1, exp1);
      chk_rd(ADDR_EVT_CNT2, exp2);
    end
    // Each error source: raise, mask, clear, software set, read-clear
    for (i = 0; i < 4; i++) begin
      b = 32'h1 << bitpos[i];
      @(posedge clk);
      err_req <= 4'(1 << i);
      @(posedge clk);
      err_req <= '0;
      repeat (2) tick();
      chk_rd(ADDR_IRQ_RAW, b);
      `CHK(irq, 1'b0)
      wr(ADDR_IRQ_ENSET, b);
      `CHK(irq, 1'b1)
      chk_rd(ADDR_IRQ_ENSET, b);
      chk_rd(ADDR_IRQ_ENCLR, b);
      wr(ADDR_IRQ_STAT, b);
      chk_rd(ADDR_IRQ_RAW, 32'h0);
      `CHK(irq, 1'b0)
      wr(ADDR_IRQ_RAW, 32'h0);
      chk_rd(ADDR_IRQ_RAW, 32'h0);
      wr(ADDR_IRQ_RAW, b);
      `CHK(irq, 1'b1)
      chk_rd(ADDR_IRQ_STAT, b);
      chk_rd(ADDR_IRQ_RAW, 32'h0);
      wr(ADDR_IRQ_ENCLR, b);
    end
    // Reserved raw bits stay clear while every source is set
    wr(ADDR_IRQ_RAW, 32'hffff_ffff);
    chk_rd(ADDR_IRQ_RAW, IRQ_BITS_MASK);
    `CHK(irq, 1'b0)
    wr(ADDR_IRQ_ENSET, 32'hffff_ffff);
    chk_rd(ADDR_IRQ_ENCLR, IRQ_BITS_MASK);
    `CHK(irq, 1'b1)
    wr(ADDR_IRQ_STAT, 32'hffff_ffff);
    chk_rd(ADDR_IRQ_RAW, 32'h0);
    `CHK(irq, 1'b0)
    final_report();
  end
endmodule
